// >>> pulse_timer.sv
// Purpose: 8-bit interval timer, square wave and PWM generator
// Assumes: CPU byte accesses on mclk; port pins come from outside the domain
// Notes: Period and mode must only be changed while the timer is stopped
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Counter equal to period value raises interrupt and clears counter together.
// - Reset clears period, duty and mode registers to zero.
// - Interval mode ignores the duty value entirely.
// - A duty match never raises the interrupt.
// - Duty writes while running wait in a buffer until an active duty match.
// - A write in the transfer cycle cancels that transfer.
// - Bit 7 runs the counter; clearing it stops and zeroes the counter.
// - Bits 6..4 pick main clock /2, /8, /64, /256, /1024 or neighbour.
// - Bits 3..2 pick interval mode (00) or PWM mode (10).
// - Bit 1 sets idle output level; bit 0 enables timer output.
// - Interval mode with output enabled toggles output on every period match.
// - Interval interrupts repeat every period value plus one count clocks.
// - Counting begins one to two count clocks after enabling.
// - Stopping forces interrupt and output inactive.
// - PWM: period match sets output active; duty match sets it inactive.
// - A new duty value needs three count clocks before it transfers.
module pulse_timer
  import pulse_timer_pkg::*;
#(
  parameter int PRESCALE_W = 10
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic neighbour_out,
  input wire logic [7:0] port5_pin_in,
  output logic [7:0] port5_pin_out,
  output logic [7:0] port5_pin_oe,
  output logic period_match_irq
);

  import pulse_timer_pkg::*;

  logic [7:0] mode_r;
  logic [7:0] period_match_value_r;
  logic [7:0] duty_buf_r;
  logic [7:0] duty_act_r;
  logic duty_pending_r;
  logic [1:0] duty_age_r;
  logic [7:0] port5_direction_r;
  logic [7:0] port5_output_latch_r;
  logic [7:0] pin_meta_r;
  logic [7:0] pin_sync_r;
  logic [7:0] count_r;
  cmp_phase_e phase_r;
  logic start_mask_r;
  logic run_d_r;
  logic out_active_r;

  logic wr_mode;
  logic wr_period;
  logic wr_duty;
  logic wr_dir;
  logic wr_latch;
  logic count_run_enable;
  logic [2:0] tick_select;
  logic [1:0] op_select;
  logic idle_output_level;
  logic output_drive_enable;
  logic pwm_mode;
  logic tick;
  logic live_tick;
  logic period_hit;
  logic duty_hit;
  logic duty_transfer;
  logic pulse_output;

  assign wr_mode = reg_wr && (reg_addr == ADDR_MODE);
  assign wr_period = reg_wr && (reg_addr == ADDR_PERIOD);
  assign wr_duty = reg_wr && (reg_addr == ADDR_DUTY);
  assign wr_dir = reg_wr && (reg_addr == ADDR_PORT5_DIR);
  assign wr_latch = reg_wr && (reg_addr == ADDR_PORT5_LATCH);

  assign count_run_enable = mode_r[RUN_BIT];
  assign tick_select = mode_r[TICK_SEL_HI:TICK_SEL_LO];
  assign op_select = mode_r[OP_SEL_HI:OP_SEL_LO];
  assign idle_output_level = mode_r[IDLE_LEVEL_BIT];
  assign output_drive_enable = mode_r[DRIVE_EN_BIT];
  // Reserved mode codes behave as interval mode
  assign pwm_mode = (op_select == OP_PWM);

  tick_gen #(
    .PRESCALE_W(PRESCALE_W)
  ) u_tick_gen (
    .mclk(mclk),
    .resetn(resetn),
    .sel(tick_select),
    .neighbour_out(neighbour_out),
    .tick(tick)
  );

  // Registers

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      mode_r <= RST_MODE;
    else if (wr_mode)
      mode_r <= reg_wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      period_match_value_r <= RST_PERIOD;
    else if (wr_period)
      period_match_value_r <= reg_wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      duty_buf_r <= RST_DUTY;
    else if (wr_duty)
      duty_buf_r <= reg_wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      port5_direction_r <= RST_PORT5_DIR;
    else if (wr_dir)
      port5_direction_r <= reg_wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      port5_output_latch_r <= RST_PORT5_LATCH;
    else if (wr_latch)
      port5_output_latch_r <= reg_wdata;
  end

  // Pin inputs cross in from outside the clock domain
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      pin_meta_r <= 8'h00;
      pin_sync_r <= 8'h00;
    end
    else
    begin
      pin_meta_r <= port5_pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // Start control: first count clock after enabling is swallowed

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      run_d_r <= 1'b0;
    else
      run_d_r <= count_run_enable;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      start_mask_r <= 1'b0;
    else if (!count_run_enable)
      start_mask_r <= 1'b0;
    else if (!run_d_r)
      start_mask_r <= 1'b1;
    else if (tick)
      start_mask_r <= 1'b0;
  end

  assign live_tick = count_run_enable && run_d_r && !start_mask_r && tick;

  // Compare events

  assign period_hit = live_tick && (phase_r == PHASE_PERIOD)
    && (count_r == period_match_value_r);
  assign duty_hit = live_tick && pwm_mode && (phase_r == PHASE_DUTY)
    && (count_r == duty_act_r);

  // Counter

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      count_r <= 8'h00;
    else if (!count_run_enable)
      count_r <= 8'h00;
    else if (period_hit)
      count_r <= 8'h00;
    else if (live_tick)
      count_r <= count_r + 8'h01;
  end

  // Which compare value the counter is checked against

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      phase_r <= PHASE_PERIOD;
    else if (!count_run_enable || !pwm_mode)
      phase_r <= PHASE_PERIOD;
    else
    begin
      case (phase_r)
        PHASE_PERIOD:
          if (period_hit)
            phase_r <= PHASE_DUTY;
        PHASE_DUTY:
          if (duty_hit)
            phase_r <= PHASE_PERIOD;
        default:
          phase_r <= PHASE_PERIOD;
      endcase
    end
  end

  // Duty buffering

  // A pending value may move only after enough count clocks since the write
  assign duty_transfer = duty_hit && duty_pending_r
    && (duty_age_r == DUTY_SETTLE_TICKS) && !wr_duty;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      duty_act_r <= RST_DUTY;
    else if (wr_duty && !count_run_enable)
      duty_act_r <= reg_wdata;
    else if (duty_transfer)
      duty_act_r <= duty_buf_r;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      duty_pending_r <= 1'b0;
    else if (wr_duty)
      duty_pending_r <= count_run_enable;
    else if (duty_transfer)
      duty_pending_r <= 1'b0;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      duty_age_r <= 2'h0;
    else if (wr_duty)
      duty_age_r <= 2'h0;
    else if (live_tick && duty_age_r != DUTY_SETTLE_TICKS)
      duty_age_r <= duty_age_r + 2'h1;
  end

  // Timer output flip-flop, held as active/inactive

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      out_active_r <= 1'b0;
    else if (!count_run_enable)
      out_active_r <= 1'b0;
    else if (pwm_mode)
    begin
      if (period_hit)
        out_active_r <= 1'b1;
      else if (duty_hit)
        out_active_r <= 1'b0;
    end
    else if (period_hit && output_drive_enable)
      out_active_r <= ~out_active_r;
  end

  assign pulse_output = out_active_r ^ idle_output_level;

  // Interrupt request: one mclk pulse per period match, duty matches excluded

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      period_match_irq <= 1'b0;
    else
      period_match_irq <= count_run_enable && period_hit;
  end

  // Port 5 pins; with output enabled, the shared pin carries the timer output ANDed with the inverted latch bit

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      port5_pin_out <= RST_PORT5_LATCH;
      port5_pin_oe <= ~RST_PORT5_DIR;
    end
    else
    begin
      port5_pin_oe <= ~port5_direction_r;
      for (int i = 0; i < 8; i++)
      begin
        if (i == TIMER_PIN && output_drive_enable)
          port5_pin_out[i] <= pulse_output & ~port5_output_latch_r[i];
        else
          port5_pin_out[i] <= port5_output_latch_r[i];
      end
    end
  end

  // Read data, valid the cycle after reg_rd

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        ADDR_MODE: reg_rdata <= mode_r;
        ADDR_PERIOD: reg_rdata <= period_match_value_r;
        ADDR_DUTY: reg_rdata <= duty_buf_r;
        ADDR_PORT5_DIR: reg_rdata <= port5_direction_r;
        ADDR_PORT5_LATCH:
        begin
          for (int i = 0; i < 8; i++)
            reg_rdata[i] <= port5_direction_r[i] ? pin_sync_r[i] : port5_output_latch_r[i];
        end
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule : pulse_timer

`default_nettype wire

// >>> pulse_timer_pkg.sv
// Purpose: Shared constants for the 8-bit interval/PWM pulse timer
// Assumes: Byte-wide register port on the CPU memory map
// Notes: Mode field encodings and count clock divider widths
`default_nettype none

package pulse_timer_pkg;

  localparam logic [15:0] ADDR_PORT5_LATCH = 16'hFF05;
  localparam logic [15:0] ADDR_PORT5_DIR = 16'hFF25;
  localparam logic [15:0] ADDR_MODE = 16'hFF2A;
  localparam logic [15:0] ADDR_PERIOD = 16'hFF18;
  localparam logic [15:0] ADDR_DUTY = 16'hFF19;

  localparam logic [7:0] RST_PORT5_DIR = 8'hFF;
  localparam logic [7:0] RST_PORT5_LATCH = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_PERIOD = 8'h00;
  localparam logic [7:0] RST_DUTY = 8'h00;

  localparam int RUN_BIT = 7;
  localparam int TICK_SEL_HI = 6;
  localparam int TICK_SEL_LO = 4;
  localparam int OP_SEL_HI = 3;
  localparam int OP_SEL_LO = 2;
  localparam int IDLE_LEVEL_BIT = 1;
  localparam int DRIVE_EN_BIT = 0;

  localparam int TIMER_PIN = 2;

  localparam logic [2:0] TICK_DIV2 = 3'h0;
  localparam logic [2:0] TICK_DIV8 = 3'h1;
  localparam logic [2:0] TICK_DIV64 = 3'h2;
  localparam logic [2:0] TICK_DIV256 = 3'h3;
  localparam logic [2:0] TICK_DIV1024 = 3'h4;
  localparam logic [2:0] TICK_NEIGHBOUR = 3'h5;

  localparam int DIV2_BITS = 1;
  localparam int DIV8_BITS = 3;
  localparam int DIV64_BITS = 6;
  localparam int DIV256_BITS = 8;
  localparam int DIV1024_BITS = 10;

  localparam logic [1:0] OP_INTERVAL = 2'h0;
  localparam logic [1:0] OP_PWM = 2'h2;

  localparam logic [1:0] DUTY_SETTLE_TICKS = 2'h3;

  typedef enum logic {PHASE_PERIOD, PHASE_DUTY} cmp_phase_e;

endpackage : pulse_timer_pkg

`default_nettype wire

// >>> pulse_timer_properties.sv
// Purpose: Port-level properties of the pulse timer
// Assumes: Registers change only through byte bus writes on mclk
// Notes: Mode, period and latch are shadowed from bus writes
`timescale 1ns/1ps
`default_nettype none

module pulse_timer_properties
  import pulse_timer_pkg::*;
#(
  parameter int PRESCALE_W = 10
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic neighbour_out,
  input wire logic [7:0] port5_pin_in,
  input wire logic [7:0] port5_pin_out,
  input wire logic [7:0] port5_pin_oe,
  input wire logic period_match_irq
);
  logic [7:0] mode_r;
  logic [7:0] per_r;
  logic [7:0] lat_r;
  logic [3:0] stop_r;
  logic [11:0] gap_r;
  logic gap_ok_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      mode_r <= RST_MODE;
      per_r <= RST_PERIOD;
      lat_r <= RST_PORT5_LATCH;
    end
    else if (reg_wr)
    begin
      if (reg_addr == ADDR_MODE)
        mode_r <= reg_wdata;
      if (reg_addr == ADDR_PERIOD)
        per_r <= reg_wdata;
      if (reg_addr == ADDR_PORT5_LATCH)
        lat_r <= reg_wdata;
    end
  end

  // Cycles spent stopped with no bus write
  always_ff @(posedge mclk)
  begin
    if (!resetn || mode_r[7] || reg_wr)
      stop_r <= 4'h0;
    else if (stop_r != 4'hF)
      stop_r <= stop_r + 4'h1;
  end

  // Spacing between requests, void after any write
  always_ff @(posedge mclk)
  begin
    if (!resetn || reg_wr)
    begin
      gap_r <= 12'h000;
      gap_ok_r <= 1'b0;
    end
    else if (period_match_irq)
    begin
      gap_r <= 12'h001;
      gap_ok_r <= 1'b1;
    end
    else
      gap_r <= gap_r + 12'h001;
  end

  AST_IRQ_ONE_CYCLE: assert property (period_match_irq |=> !period_match_irq)
    else $error("irq longer than one cycle");
  AST_IRQ_SPACING: assert property (period_match_irq && gap_ok_r && mode_r[6:4] == TICK_DIV2
    |-> gap_r == {3'h0, per_r, 1'b0} + 12'h002)
    else $error("irq spacing wrong");
  AST_STOP_NO_IRQ: assert property (stop_r >= 4'h2 |-> !period_match_irq)
    else $error("irq while stopped");
  AST_STOP_PIN_IDLE: assert property (stop_r >= 4'h4 |-> port5_pin_out[2] ==
    (mode_r[0] ? mode_r[1] & ~lat_r[2] : lat_r[2]))
    else $error("pin not idle while stopped");
  AST_OE_FOLLOWS_DIR: assert property (reg_wr && reg_addr == ADDR_PORT5_DIR
    |-> ##2 port5_pin_oe == ~$past(reg_wdata, 2))
    else $error("oe not inverse of direction");
  AST_READ_MODE: assert property (reg_rd && reg_addr == ADDR_MODE |=> reg_rdata == $past(mode_r))
    else $error("mode read wrong");
  AST_READ_PERIOD: assert property (reg_rd && reg_addr == ADDR_PERIOD |=> reg_rdata == $past(per_r))
    else $error("period read wrong");
  AST_FIRST_IRQ: assert property ($rose(mode_r[7]) && mode_r[6:4] == TICK_DIV2
    |-> ##[1:530] (period_match_irq || !mode_r[7]))
    else $error("no irq after start");
  AST_RESTART_FROM_ZERO: assert property ($rose(mode_r[7]) && mode_r[6:4] == TICK_DIV2
    && per_r == 8'h03 |-> !period_match_irq [*6])
    else $error("irq too early after start");
endmodule : pulse_timer_properties

bind pulse_timer pulse_timer_properties #(.PRESCALE_W(PRESCALE_W)) i_pulse_timer_properties (
  .mclk(mclk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .neighbour_out(neighbour_out),
  .port5_pin_in(port5_pin_in), .port5_pin_out(port5_pin_out), .port5_pin_oe(port5_pin_oe),
  .period_match_irq(period_match_irq));

`default_nettype wire

// >>> testbench.sv
// Purpose: Self-checking bench for the pulse timer
// Assumes: Inputs change by NBA at mclk rising edges
// Notes: Spacing and duty are judged in mclk cycles
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import pulse_timer_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic reg_wr = 1'b0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic nb_out = 1'b0;
  logic [1:0] nb_div = 2'h0;
  logic [7:0] pin_out;
  logic [7:0] pin_oe;
  logic irq;
  logic [15:0] n;
  logic [15:0] h;
  logic [15:0] q;
  logic [15:0] gaps [6] = '{16'h2, 16'h8, 16'h40, 16'h100, 16'h400, 16'h6};
  int miscompares = 0;
  int tests_run = 0;
  // Pins read back with a pull-up where not driven
  wire logic [7:0] pin_lvl = (pin_out & pin_oe) | ~pin_oe;

  always #10 mclk = ~mclk;

  // Neighbour output rises every six mclk, high half the time
  always @(posedge mclk)
  begin
    nb_div <= (nb_div == 2'h2) ? 2'h0 : nb_div + 2'h1;
    if (nb_div == 2'h2)
      nb_out <= ~nb_out;
  end

  pulse_timer #(.PRESCALE_W(10)) i_pulse_timer (.mclk(mclk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .neighbour_out(nb_out), .port5_pin_in(pin_lvl),
    .port5_pin_out(pin_out), .port5_pin_oe(pin_oe), .period_match_irq(irq));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask : rdc

  task automatic next_irq(output logic [15:0] c);
    c = 16'h0000;
    do
    begin
      @(posedge mclk);
      #1;
      c = c + 16'h0001;
    end
    while (irq !== 1'b1 && c < 16'h1000);
  endtask : next_irq

  task automatic sample(input int cyc, output logic [15:0] hi, output logic [15:0] iq);
    hi = 16'h0000;
    iq = 16'h0000;
    repeat (cyc)
    begin
      @(posedge mclk);
      #1;
      hi = hi + 16'(pin_out[2]);
      iq = iq + 16'(irq);
    end
  endtask : sample

  task automatic t_reset();
    rdc(ADDR_MODE, 8'h00);
    rdc(ADDR_PERIOD, 8'h00);
    rdc(ADDR_DUTY, 8'h00);
    rdc(ADDR_PORT5_DIR, 8'hFF);
    rdc(16'hFF00, 8'h00);
    rdc(ADDR_PORT5_LATCH, 8'hFF);
    chk({8'h00, pin_oe}, 16'h0000);
    $display("done reset");
  endtask : t_reset

  task automatic t_interval();
    wr(ADDR_PORT5_DIR, 8'hFB);
    @(posedge mclk);
    #1;
    chk({8'h00, pin_oe}, 16'h0004);
    wr(ADDR_PERIOD, 8'h03);
    wr(ADDR_DUTY, 8'h01);
    wr(ADDR_MODE, 8'h81);
    next_irq(n);
    next_irq(n);
    chk(n, 16'h0008);
    sample(32, h, q);
    chk(h, 16'h0010);
    chk(q, 16'h0004);
    wr(ADDR_MODE, 8'h01);
    sample(40, h, q);
    chk(q, 16'h0000);
    chk({15'h0, pin_out[2]}, 16'h0000);
    wr(ADDR_MODE, 8'h81);
    next_irq(n);
    chk(16'(n >= 16'h7 && n <= 16'hC), 16'h0001);
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_MODE, 8'h03);
    sample(6, h, q);
    chk({15'h0, pin_out[2]}, 16'h0001);
    wr(ADDR_MODE, 8'h02);
    sample(6, h, q);
    chk({15'h0, pin_out[2]}, 16'h0000);
    $display("done interval");
  endtask : t_interval

  task automatic t_pwm();
    wr(ADDR_PERIOD, 8'h07);
    wr(ADDR_DUTY, 8'h02);
    wr(ADDR_MODE, 8'h89);
    next_irq(n);
    sample(32, h, q);
    chk(h, 16'h000C);
    chk(q, 16'h0002);
    wr(ADDR_DUTY, 8'h04);
    rdc(ADDR_DUTY, 8'h04);
    sample(40, h, q);
    sample(32, h, q);
    chk(h, 16'h0014);
    wr(ADDR_MODE, 8'h09);
    wr(ADDR_DUTY, 8'h01);
    wr(ADDR_MODE, 8'h89);
    next_irq(n);
    sample(32, h, q);
    chk(h, 16'h0008);
    wr(ADDR_MODE, 8'h09);
    $display("done pwm");
  endtask : t_pwm

  task automatic t_ticks();
    wr(ADDR_PERIOD, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      wr(ADDR_MODE, 8'h80 | 8'(i << 4));
      next_irq(n);
      next_irq(n);
      chk(n, gaps[i]);
      wr(ADDR_MODE, 8'(i << 4));
    end
    wr(ADDR_MODE, 8'hE0);
    sample(64, h, q);
    chk(q, 16'h0000);
    wr(ADDR_MODE, 8'h60);
    $display("done ticks");
  endtask : t_ticks

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  initial
  begin
    #400000;
    miscompares++;
    print_verdict();
  end

  initial
  begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_interval();
    t_pwm();
    t_ticks();
    print_verdict();
  end
endmodule : testbench

`default_nettype wire

// >>> tick_gen.sv
// Purpose: Count clock enable from main clock prescaler or neighbour timer
// Assumes: Neighbour timer output is logic on the same mclk
// Notes: Prescaler runs freely, so the first tick after start may come early
`timescale 1ns/1ps
`default_nettype none

module tick_gen
  import pulse_timer_pkg::*;
#(
  parameter int PRESCALE_W = 10
)
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [2:0] sel,
  input wire logic neighbour_out,
  output logic tick
);

  logic [PRESCALE_W-1:0] pre_r;
  logic nb_d_r;
  logic tick_nxt;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      pre_r <= '0;
    else
      pre_r <= pre_r + 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      nb_d_r <= 1'b0;
    else
      nb_d_r <= neighbour_out;
  end

  // One pulse per selected divided period; reserved codes give no ticks
  always_comb
  begin
    case (sel)
      TICK_DIV2: tick_nxt = &pre_r[DIV2_BITS-1:0];
      TICK_DIV8: tick_nxt = &pre_r[DIV8_BITS-1:0];
      TICK_DIV64: tick_nxt = &pre_r[DIV64_BITS-1:0];
      TICK_DIV256: tick_nxt = &pre_r[DIV256_BITS-1:0];
      TICK_DIV1024: tick_nxt = &pre_r[DIV1024_BITS-1:0];
      TICK_NEIGHBOUR: tick_nxt = neighbour_out & ~nb_d_r;
      default: tick_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      tick <= 1'b0;
    else
      tick <= tick_nxt;
  end

endmodule : tick_gen

`default_nettype wire
